/* File: core/pll_clk_ctrl_decode.sv */
`timescale 1ns/1ns
`default_nettype none
module pll_clk_ctrl_decode (
   // raw register
   input  wire logic [7:0]                 reg_in,
   // decoded fields
   output var  pll_clk_ctrl_pkg::clk_ctrl_t fields_out
);
   logic [1:0] src;
   logic [1:0] osc;

   // field decode
   always_comb begin
      src = reg_in[pll_clk_ctrl_pkg::POS_SRC_HI:pll_clk_ctrl_pkg::POS_SRC_LO];
      osc = reg_in[pll_clk_ctrl_pkg::POS_OSC_HI:pll_clk_ctrl_pkg::POS_OSC_LO];
      fields_out.src_frame_clk = (src == pll_clk_ctrl_pkg::SRC_FRAME_CLK);
      fields_out.src_reserved  = (src != pll_clk_ctrl_pkg::SRC_FRAME_CLK) &&
                                 (src != pll_clk_ctrl_pkg::SRC_MCLK_XTAL);
      fields_out.osc_enable    = (osc != pll_clk_ctrl_pkg::OSC_OFF);
      fields_out.osc_reserved  = (osc != pll_clk_ctrl_pkg::OSC_OFF) &&
                                 (osc != pll_clk_ctrl_pkg::OSC_RUN);
      fields_out.soft_reset    = reg_in[pll_clk_ctrl_pkg::POS_SOFT_RST];
      fields_out.ratio_code    =
         reg_in[pll_clk_ctrl_pkg::POS_RATIO_HI:pll_clk_ctrl_pkg::POS_RATIO_LO];
      fields_out.power_up      = reg_in[pll_clk_ctrl_pkg::POS_PUP];
      // ratio table
      case (fields_out.ratio_code)
         2'h0:    fields_out.ratio_mult = pll_clk_ctrl_pkg::RATIO_256;
         2'h1:    fields_out.ratio_mult = pll_clk_ctrl_pkg::RATIO_384;
         2'h2:    fields_out.ratio_mult = pll_clk_ctrl_pkg::RATIO_512;
         default: fields_out.ratio_mult = pll_clk_ctrl_pkg::RATIO_768;
      endcase
   end
endmodule : pll_clk_ctrl_decode
`default_nettype wire

/* File: core/pll_clk_ctrl_pkg.sv */
package pll_clk_ctrl_pkg;
   // register map
   localparam logic [7:0] ADDR_CTRL_ZERO   = 8'h00;
   localparam logic [7:0] ADDR_CTRL_ONE    = 8'h01;
   localparam logic [7:0] RST_CTRL_ZERO    = 8'h00;
   // field positions
   localparam int         POS_SRC_HI       = 7;
   localparam int         POS_SRC_LO       = 6;
   localparam int         POS_OSC_HI       = 5;
   localparam int         POS_OSC_LO       = 4;
   localparam int         POS_SOFT_RST     = 3;
   localparam int         POS_RATIO_HI     = 2;
   localparam int         POS_RATIO_LO     = 1;
   localparam int         POS_PUP          = 0;
   // field codes
   localparam logic [1:0] SRC_MCLK_XTAL    = 2'h0;
   localparam logic [1:0] SRC_FRAME_CLK    = 2'h1;
   localparam logic [1:0] OSC_RUN          = 2'h0;
   localparam logic [1:0] OSC_OFF          = 2'h3;
   // ratio multipliers
   localparam logic [9:0] RATIO_256        = 10'h100;
   localparam logic [9:0] RATIO_384        = 10'h180;
   localparam logic [9:0] RATIO_512        = 10'h200;
   localparam logic [9:0] RATIO_768        = 10'h300;

   // decoded control fields
   typedef struct packed {
      logic       src_frame_clk;
      logic       src_reserved;
      logic       osc_enable;
      logic       osc_reserved;
      logic       soft_reset;
      logic [1:0] ratio_code;
      logic [9:0] ratio_mult;
      logic       power_up;
   } clk_ctrl_t;
endpackage : pll_clk_ctrl_pkg

/* File: core/pll_clock_control_reg0.sv */
`timescale 1ns/1ns
`default_nettype none
module pll_clock_control_reg0 (
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   // register port from the control interface
   input  wire logic       wr_en_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       rd_en_in,
   output logic      [7:0] rdata_out,
   // clock-select bit from the neighbouring register
   input  wire logic       direct_clk_sel_in,
   // controls to the clock subsystem
   output logic            pll_src_frame_clk_out,
   output logic            crystal_osc_en_out,
   output logic [1:0]      mclk_ratio_select_out,
   output logic [9:0]      mclk_ratio_mult_out,
   output logic            core_reset_out,
   output logic            ctrl_regs_reset_out,
   output logic            master_power_up_out,
   output logic            dac_clk_from_pll_out,
   output logic            reserved_code_out,
   output logic            first_write_bad_out
);
   logic [7:0]                  ctrl_ff,     nxt_ctrl;
   logic [7:0]                  rdata_ff,    nxt_rdata;
   logic                        seen_wr_ff,  nxt_seen_wr;
   logic                        bad_ff,      nxt_bad;
   logic                        src_ff,      nxt_src;
   logic                        osc_ff,      nxt_osc;
   logic [1:0]                  rcode_ff,    nxt_rcode;
   logic [9:0]                  rmult_ff,    nxt_rmult;
   logic                        core_rst_ff, nxt_core_rst;
   logic                        regs_rst_ff, nxt_regs_rst;
   logic                        pup_ff,      nxt_pup;
   logic                        fromp_ff,    nxt_fromp;
   logic                        resv_ff,     nxt_resv;
   pll_clk_ctrl_pkg::clk_ctrl_t fields;

   // field decoder
   pll_clk_ctrl_decode u_decode (
      .reg_in     (ctrl_ff),
      .fields_out (fields)
   );

   // register write, readback and host-order tracking
   always_comb begin
      nxt_ctrl    = ctrl_ff;
      nxt_rdata   = rdata_ff;
      nxt_seen_wr = seen_wr_ff;
      nxt_bad     = bad_ff;
      if (wr_en_in && (addr_in == pll_clk_ctrl_pkg::ADDR_CTRL_ZERO)) begin
         nxt_ctrl = wdata_in; // soft reset never clears this register
      end
      if (wr_en_in && !seen_wr_ff) begin
         nxt_seen_wr = 1'b1;
         // first write must set power-up
         nxt_bad = !((addr_in == pll_clk_ctrl_pkg::ADDR_CTRL_ZERO) &&
                     wdata_in[pll_clk_ctrl_pkg::POS_PUP]);
      end
      if (rd_en_in) begin
         if (addr_in == pll_clk_ctrl_pkg::ADDR_CTRL_ZERO) begin
            nxt_rdata = ctrl_ff;
         end else begin
            nxt_rdata = 8'h00;
         end
      end
   end

   // control outputs follow the stored fields, except the DAC clock source, which is the inverse of direct_clk_sel_in
   always_comb begin
      nxt_src      = fields.src_frame_clk;
      nxt_osc      = fields.osc_enable;
      nxt_rcode    = fields.ratio_code;
      nxt_rmult    = fields.ratio_mult;
      nxt_core_rst = fields.soft_reset;
      nxt_regs_rst = fields.soft_reset; // other registers only
      nxt_pup      = fields.power_up;
      nxt_fromp    = !direct_clk_sel_in;
      nxt_resv     = fields.src_reserved || fields.osc_reserved;
   end

   // state registers, cleared to defaults by hardware reset
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ctrl_ff     <= pll_clk_ctrl_pkg::RST_CTRL_ZERO;
         rdata_ff    <= 8'h00;
         seen_wr_ff  <= 1'b0;
         bad_ff      <= 1'b0;
         src_ff      <= 1'b0;
         osc_ff      <= 1'b1;
         rcode_ff    <= 2'h0;
         rmult_ff    <= pll_clk_ctrl_pkg::RATIO_256;
         core_rst_ff <= 1'b0;
         regs_rst_ff <= 1'b0;
         pup_ff      <= 1'b0;
         fromp_ff    <= 1'b1;
         resv_ff     <= 1'b0;
      end else begin
         ctrl_ff     <= nxt_ctrl;
         rdata_ff    <= nxt_rdata;
         seen_wr_ff  <= nxt_seen_wr;
         bad_ff      <= nxt_bad;
         src_ff      <= nxt_src;
         osc_ff      <= nxt_osc;
         rcode_ff    <= nxt_rcode;
         rmult_ff    <= nxt_rmult;
         core_rst_ff <= nxt_core_rst;
         regs_rst_ff <= nxt_regs_rst;
         pup_ff      <= nxt_pup;
         fromp_ff    <= nxt_fromp;
         resv_ff     <= nxt_resv;
      end
   end

   // outputs straight from flops
   assign rdata_out             = rdata_ff;
   assign pll_src_frame_clk_out = src_ff;
   assign crystal_osc_en_out    = osc_ff;
   assign mclk_ratio_select_out = rcode_ff;
   assign mclk_ratio_mult_out   = rmult_ff;
   assign core_reset_out        = core_rst_ff;
   assign ctrl_regs_reset_out   = regs_rst_ff;
   assign master_power_up_out   = pup_ff;
   assign dac_clk_from_pll_out  = fromp_ff;
   assign reserved_code_out     = resv_ff;
   assign first_write_bad_out   = bad_ff;
endmodule : pll_clock_control_reg0
`default_nettype wire

/* File: tb/host_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_ctrl_model (
   // clock and read data
   input  wire logic       ref_clk_in,
   input  wire logic [7:0] rdata_in,
   // register port requests
   output logic            wr_en_out, rd_en_out,
   output logic      [7:0] addr_out, wdata_out
);
   // idle bus
   initial begin
      {wr_en_out, rd_en_out, addr_out, wdata_out} = 18'h0;
   end
   // one write, held across its sampling edge, then bus released
   task automatic wr(input logic [7:0] a, d);
      @(posedge ref_clk_in) #2;
      {wr_en_out, addr_out, wdata_out} = {1'b1, a, d};
      @(posedge ref_clk_in) #2;
      {wr_en_out, addr_out, wdata_out} = {1'b0, ~a, ~d};
   endtask : wr
   // one read, data taken one edge later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_in) #2;
      {rd_en_out, addr_out} = {1'b1, a};
      @(posedge ref_clk_in) #2;
      {rd_en_out, addr_out} = {1'b0, ~a};
      d = rdata_in;
   endtask : rd
endmodule : host_ctrl_model
`default_nettype wire

/* File: tb/pll_clock_control_reg0_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module pll_clock_control_reg0_tb;
   logic       ref_clk_in = 1'b0, rst_n_in = 1'b0, direct_clk_sel_in = 1'b0;
   logic       wr_en, rd_en, src, osc, crst, rrst, master_power_up, from_pll, resv, bad;
   logic [7:0] addr, wdata, rdata, rv;
   logic [1:0] ratio;
   logic [9:0] mult;
   int         err_count = 0, num_checks = 0;
   // host keeps to legal source and oscillator codes only
   logic [7:0] vals [11] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h41, 8'h31, 8'h09, 8'h43, 8'h75, 8'h0f, 8'h35};
   always #25 ref_clk_in = ~ref_clk_in;
   host_ctrl_model host_u (.ref_clk_in(ref_clk_in), .rdata_in(rdata), .wr_en_out(wr_en),
      .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));
   pll_clock_control_reg0 dut_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en),
      .addr_in(addr), .wdata_in(wdata), .rd_en_in(rd_en), .rdata_out(rdata),
      .direct_clk_sel_in(direct_clk_sel_in), .pll_src_frame_clk_out(src), .crystal_osc_en_out(osc),
      .mclk_ratio_select_out(ratio), .mclk_ratio_mult_out(mult), .core_reset_out(crst),
      .ctrl_regs_reset_out(rrst), .master_power_up_out(master_power_up), .dac_clk_from_pll_out(from_pll),
      .reserved_code_out(resv), .first_write_bad_out(bad));
   // compare and count
   task automatic chk(input logic [17:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // expected decoded controls for a stored value
   function automatic logic [17:0] fields(input logic [7:0] d);
      fields = {d[7:6] == 2'h1, d[5:4] != 2'h3, d[2:1],
         d[2:1] == 2'h3 ? 10'h300 : 10'h100 + {1'b0, d[2:1], 7'h00}, d[3], d[3], d[0],
         d[7] | (d[5:4] == 2'h1) | (d[5:4] == 2'h2)};
   endfunction : fields
   // write, wait for the controls, then read back
   task automatic put(input logic [7:0] d);
      host_u.wr(8'h00, d);
      @(posedge ref_clk_in) #2;
      chk({src, osc, ratio, mult, crst, rrst, master_power_up, resv}, fields(d));
      host_u.rd(8'h00, rv);
      chk(18'(rv), 18'(d));
   endtask : put
   task automatic print_verdict;
      if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   // main sequence
   initial begin
      repeat (20) @(posedge ref_clk_in);
      #2 rst_n_in = 1'b1;
      chk({src, osc, ratio, mult, crst, rrst, master_power_up, resv}, fields(8'h00));
      host_u.rd(8'h00, rv);
      chk(18'(rv), 18'h0);
      foreach (vals[i]) put(vals[i]);
      chk(18'(bad), 18'h0);
      host_u.wr(8'h01, 8'hff);
      host_u.rd(8'h00, rv);
      chk(18'(rv), 18'h35);
      host_u.rd(8'h05, rv);
      chk(18'(rv), 18'h0);
      chk(18'(from_pll), 18'h1);
      direct_clk_sel_in = 1'b1;
      @(posedge ref_clk_in) #2;
      chk(18'(from_pll), 18'h0);
      rst_n_in = 1'b0;
      repeat (2) @(posedge ref_clk_in);
      #2 rst_n_in = 1'b1;
      host_u.wr(8'h06, 8'h01);
      @(posedge ref_clk_in) #2;
      chk(18'(bad), 18'h1);
      print_verdict();
   end
   // watchdog
   initial begin
      #100000;
      err_count++;
      print_verdict();
   end
endmodule : pll_clock_control_reg0_tb
`default_nettype wire

/* File: tb/pll_clock_control_zero_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module pll_clock_control_zero_monitor (
   // clock, reset and register port
   input wire logic       ref_clk_in, rst_n_in, wr_en_in, rd_en_in, direct_clk_sel_in,
   input wire logic [7:0] addr_in, wdata_in, rdata_out,
   // decoded controls
   input wire logic       pll_src_frame_clk_out, crystal_osc_en_out, core_reset_out,
   input wire logic       ctrl_regs_reset_out, master_power_up_out, dac_clk_from_pll_out,
   input wire logic [1:0] mclk_ratio_select_out,
   input wire logic [9:0] mclk_ratio_mult_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // write to this register, fields follow two edges later
   wire logic wr0 = wr_en_in && addr_in == 8'h00;
   src_select_a: assert property (wr0 |-> ##2 pll_src_frame_clk_out == ($past(wdata_in[7:6], 2) == 2'h1))
      else $error("source select wrong");
   osc_enable_a: assert property (wr0 |-> ##2 crystal_osc_en_out == ($past(wdata_in[5:4], 2) != 2'h3))
      else $error("oscillator enable wrong");
   core_reset_a: assert property (wr0 |-> ##2 core_reset_out == $past(wdata_in[3], 2))
      else $error("core reset wrong");
   regs_reset_a: assert property (wr0 |-> ##2 ctrl_regs_reset_out == $past(wdata_in[3], 2))
      else $error("register reset wrong");
   ratio_code_a: assert property (wr0 |-> ##2 mclk_ratio_select_out == $past(wdata_in[2:1], 2))
      else $error("ratio code wrong");
   ratio_mult_a: assert property (mclk_ratio_mult_out == (mclk_ratio_select_out == 2'h3 ? 10'h300 : 10'h100 + {1'b0, mclk_ratio_select_out, 7'h00}))
      else $error("ratio multiplier wrong");
   power_up_a: assert property (wr0 |-> ##2 master_power_up_out == $past(wdata_in[0], 2))
      else $error("power bit wrong");
   hw_reset_a: assert property (disable iff (1'b0) !rst_n_in |=> rdata_out == 8'h00 && !master_power_up_out && crystal_osc_en_out)
      else $error("reset state wrong");
   dac_clk_a: assert property (1'b1 |=> dac_clk_from_pll_out == !$past(direct_clk_sel_in))
      else $error("dac clock source wrong");
   other_read_a: assert property (rd_en_in && addr_in != 8'h00 |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
endmodule : pll_clock_control_zero_monitor
bind pll_clock_control_reg0 pll_clock_control_zero_monitor mon_u (.*);
`default_nettype wire
